/* hdl/cho_defines.svh */
/*
  Constants of the charger option control register: command code, field
  positions and power-on values. Assumes inclusion by bare name.
*/
`ifndef CHO_DEFINES_SVH
`define CHO_DEFINES_SVH

// ----------------------------------------------------------------
// Register access
// ----------------------------------------------------------------
`define CHO_CMD_W 8
`define CHO_CMD_OPTION 8'h12
`define CHO_DATA_W 16
`define CHO_ZERO_WORD 16'h0000

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CHO_BIT_DEPL_HI 12
`define CHO_BIT_DEPL_LO 11
`define CHO_BIT_HS_EN 8
`define CHO_BIT_LS_SEL 7
`define CHO_BIT_LEARN 6
`define CHO_BIT_MON_SEL 5
`define CHO_BIT_ADP_PRES 4
`define CHO_BIT_UNUSED_HI 3
`define CHO_BIT_UNUSED_LO 2
`define CHO_BIT_OCP_EN 1
`define CHO_BIT_INHIBIT 0

// ----------------------------------------------------------------
// Power-on values
// ----------------------------------------------------------------
`define CHO_RST_DEPL 2'h3
`define CHO_RST_HS_EN 1'h1
`define CHO_RST_LS_SEL 1'h0
`define CHO_RST_MON_SEL 1'h0
`define CHO_RST_OCP_EN 1'h1
`define CHO_RST_INHIBIT 1'h0

`endif

/* hdl/cho_option.sv */
/*
  Charger option control register, low fields plus depletion select,
  with the battery learn cycle sequencer.
  Assumes a command engine on the same clock that presents a command code
  with one-cycle write and read strobes, and analog depletion and adapter-sense
  comparators whose outputs arrive asynchronously.
*/
`timescale 1ns/1ps
`include "cho_defines.svh"

module cho_option
  import cho_pkg::*;
#(
  parameter logic [`CHO_CMD_W-1:0] OPT_CMD = `CHO_CMD_OPTION
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [`CHO_CMD_W-1:0] opt_cmd_i,
  input wire logic opt_wr_i,
  input wire logic opt_rd_i,
  input wire logic [`CHO_DATA_W-1:0] opt_wdata_i,
  input wire logic adapter_sense_input_i,
  input wire logic batt_depleted_i,
  input wire logic charge_voltage_zero_i,
  output logic [`CHO_DATA_W-1:0] opt_rdata_o,
  output logic high_side_short_threshold_sel_o,
  output logic low_side_short_threshold_sel_o,
  output logic current_monitor_output_sel_o,
  output logic input_overcurrent_protect_en_o,
  output logic charge_inhibit_o,
  output logic [1:0] depletion_threshold_sel_o,
  output logic adapter_path_switch_o,
  output logic battery_path_switch_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (OPT_CMD == '0) begin : g_bad_cmd
    $error("cho_option: OPT_CMD must be non-zero");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync_w;
  logic adp_pres_w;
  logic depl_w;

  cho_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({batt_depleted_i, adapter_sense_input_i}),
    .sync_o(sync_w)
  );

  assign adp_pres_w = sync_w[0];
  assign depl_w = sync_w[1];

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic hs_en_q, hs_en_d;
  logic ls_sel_q, ls_sel_d;
  logic mon_sel_q, mon_sel_d;
  logic ocp_en_q, ocp_en_d;
  logic inhibit_q, inhibit_d;
  logic [1:0] depl_q, depl_d;
  cho_learn_e state_q, state_d;
  logic adp_sw_q, adp_sw_d;
  logic bat_sw_q, bat_sw_d;
  cho_word_t rdata_q, rdata_d;
  logic wr_hit_w;
  logic rd_hit_w;
  logic learn_done_w;

  assign wr_hit_w = opt_wr_i && (opt_cmd_i == OPT_CMD);
  assign rd_hit_w = opt_rd_i && (opt_cmd_i == OPT_CMD);
  assign learn_done_w = (state_q == CHO_LEARN) && depl_w && !charge_voltage_zero_i;

  function automatic cho_word_t image(input logic hs, input logic ls,
                                      input logic lrn, input logic mon,
                                      input logic adp, input logic ocp,
                                      input logic inh, input logic [1:0] dp);
    cho_word_t w;
    w = `CHO_ZERO_WORD;
    w[`CHO_BIT_DEPL_HI:`CHO_BIT_DEPL_LO] = dp;
    w[`CHO_BIT_HS_EN] = hs;
    w[`CHO_BIT_LS_SEL] = ls;
    w[`CHO_BIT_LEARN] = lrn;
    w[`CHO_BIT_MON_SEL] = mon;
    w[`CHO_BIT_ADP_PRES] = adp;
    w[`CHO_BIT_OCP_EN] = ocp;
    w[`CHO_BIT_INHIBIT] = inh;
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  always_comb begin
    hs_en_d = hs_en_q;
    ls_sel_d = ls_sel_q;
    mon_sel_d = mon_sel_q;
    ocp_en_d = ocp_en_q;
    inhibit_d = inhibit_q;
    depl_d = depl_q;
    state_d = state_q;
    rdata_d = rdata_q;
    // presence bit has no write path; bits 3:2 are not stored
    if (wr_hit_w) begin
      hs_en_d = opt_wdata_i[`CHO_BIT_HS_EN];
      ls_sel_d = opt_wdata_i[`CHO_BIT_LS_SEL];
      mon_sel_d = opt_wdata_i[`CHO_BIT_MON_SEL];
      ocp_en_d = opt_wdata_i[`CHO_BIT_OCP_EN];
      inhibit_d = opt_wdata_i[`CHO_BIT_INHIBIT];
      depl_d = opt_wdata_i[`CHO_BIT_DEPL_HI:`CHO_BIT_DEPL_LO];
    end
    // software write of the learn bit wins over completion
    unique case (state_q)
      CHO_IDLE: begin
        if (wr_hit_w && opt_wdata_i[`CHO_BIT_LEARN]) begin
          state_d = CHO_LEARN;
        end
      end
      CHO_LEARN: begin
        if (wr_hit_w) begin
          state_d = opt_wdata_i[`CHO_BIT_LEARN] ? CHO_LEARN : CHO_IDLE;
        end else if (learn_done_w) begin
          state_d = CHO_IDLE;
        end
      end
    endcase
    if (rd_hit_w) begin
      rdata_d = image(hs_en_q, ls_sel_q, state_q == CHO_LEARN, mon_sel_q,
                      adp_pres_w, ocp_en_q, inhibit_q, depl_q);
    end else if (opt_rd_i) begin
      rdata_d = `CHO_ZERO_WORD;
    end
    // switches follow the learn state, never both on
    adp_sw_d = (state_d == CHO_IDLE);
    bat_sw_d = (state_d == CHO_LEARN);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hs_en_q <= `CHO_RST_HS_EN;
      ls_sel_q <= `CHO_RST_LS_SEL;
      mon_sel_q <= `CHO_RST_MON_SEL;
      ocp_en_q <= `CHO_RST_OCP_EN;
      inhibit_q <= `CHO_RST_INHIBIT;
      depl_q <= `CHO_RST_DEPL;
      state_q <= CHO_IDLE;
      adp_sw_q <= 1'b1;
      bat_sw_q <= 1'b0;
      rdata_q <= `CHO_ZERO_WORD;
    end else begin
      hs_en_q <= hs_en_d;
      ls_sel_q <= ls_sel_d;
      mon_sel_q <= mon_sel_d;
      ocp_en_q <= ocp_en_d;
      inhibit_q <= inhibit_d;
      depl_q <= depl_d;
      state_q <= state_d;
      adp_sw_q <= adp_sw_d;
      bat_sw_q <= bat_sw_d;
      rdata_q <= rdata_d;
    end
  end

  assign opt_rdata_o = rdata_q;
  assign high_side_short_threshold_sel_o = hs_en_q;
  assign low_side_short_threshold_sel_o = ls_sel_q;
  assign current_monitor_output_sel_o = mon_sel_q;
  assign input_overcurrent_protect_en_o = ocp_en_q;
  assign charge_inhibit_o = inhibit_q;
  assign depletion_threshold_sel_o = depl_q;
  assign adapter_path_switch_o = adp_sw_q;
  assign battery_path_switch_o = bat_sw_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_hs_write;
    wr_hit_w |=> high_side_short_threshold_sel_o == $past(opt_wdata_i[`CHO_BIT_HS_EN]);
  endproperty
  a_hs_write: assert property (p_hs_write) else $error("high-side enable not written");

  property p_ls_hold;
    !wr_hit_w |=> $stable(low_side_short_threshold_sel_o);
  endproperty
  a_ls_hold: assert property (p_ls_hold) else $error("low-side select changed w/o write");

  property p_learn_start;
    wr_hit_w && opt_wdata_i[`CHO_BIT_LEARN] |=> battery_path_switch_o && !adapter_path_switch_o;
  endproperty
  a_learn_start: assert property (p_learn_start) else $error("learn did not start");

  property p_learn_done;
    (state_q == CHO_LEARN) && depl_w && !charge_voltage_zero_i && !wr_hit_w
      |=> adapter_path_switch_o && !battery_path_switch_o && state_q == CHO_IDLE;
  endproperty
  a_learn_done: assert property (p_learn_done) else $error("learn did not finish");

  property p_learn_clear;
    learn_done_w && !wr_hit_w ##1 !wr_hit_w ##1 rd_hit_w
      |=> !opt_rdata_o[`CHO_BIT_LEARN];
  endproperty
  a_learn_clear: assert property (p_learn_clear) else $error("learn bit not cleared");

  property p_learn_abort;
    wr_hit_w && !opt_wdata_i[`CHO_BIT_LEARN] |=> adapter_path_switch_o && !battery_path_switch_o;
  endproperty
  a_learn_abort: assert property (p_learn_abort) else $error("learn abort failed");

  property p_mon_write;
    wr_hit_w |=> current_monitor_output_sel_o == $past(opt_wdata_i[`CHO_BIT_MON_SEL]);
  endproperty
  a_mon_write: assert property (p_mon_write) else $error("monitor select not written");

  property p_adp_read;
    rd_hit_w |=> opt_rdata_o[`CHO_BIT_ADP_PRES] == $past(adp_pres_w);
  endproperty
  a_adp_read: assert property (p_adp_read) else $error("presence bit wrong");

  property p_ocp_inh;
    wr_hit_w |=> {input_overcurrent_protect_en_o, charge_inhibit_o} ==
                 $past({opt_wdata_i[`CHO_BIT_OCP_EN], opt_wdata_i[`CHO_BIT_INHIBIT]});
  endproperty
  a_ocp_inh: assert property (p_ocp_inh) else $error("protect or inhibit not written");

  property p_inh_hold;
    charge_inhibit_o && !wr_hit_w |=> charge_inhibit_o;
  endproperty
  a_inh_hold: assert property (p_inh_hold) else $error("inhibit dropped on its own");

  property p_vzero_hold;
    (state_q == CHO_LEARN) && charge_voltage_zero_i && !wr_hit_w
      |=> battery_path_switch_o;
  endproperty
  a_vzero_hold: assert property (p_vzero_hold) else $error("depletion acted at zero volts");

  property p_unused;
    rd_hit_w |=> opt_rdata_o[`CHO_BIT_UNUSED_HI:`CHO_BIT_UNUSED_LO] == 2'h0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");

endmodule // cho_option

/* hdl/cho_pkg.sv */
/*
  Types of the charger option control block.
  Assumes the constants header is compiled alongside.
*/
package cho_pkg;

  typedef enum logic {
    CHO_IDLE,
    CHO_LEARN
  } cho_learn_e;

  typedef logic [15:0] cho_word_t;

endpackage

/* hdl/cho_sync.sv */
/*
  Three-flop input synchroniser with agreement filter.
  Assumes inputs asynchronous to sys_clk_i; output changes once stages
  two and three agree.
*/
`timescale 1ns/1ps

module cho_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (WIDTH < 1) begin : g_bad_width
    $error("cho_sync: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] out_d;

  // ----------------------------------------------------------------
  // Filter
  // ----------------------------------------------------------------
  // Stage one feeds stage two only
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;

endmodule // cho_sync

/* test/cho_host_model.sv */
/*
  Host model: power management controller driving the option command port.
  Assumes the bench calls xfer and shares the device clock.
*/
`timescale 1ns/1ps
`include "cho_defines.svh"

module cho_host_model (
  input wire logic sys_clk_i,
  output logic [`CHO_CMD_W-1:0] cmd_o,
  output logic wr_o,
  output logic rd_o,
  output logic [`CHO_DATA_W-1:0] wdata_o,
  input wire logic [`CHO_DATA_W-1:0] rdata_i
);
  initial begin
    cmd_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 16'h0000;
  end

  // ----------------------------------------------------------------
  // One access: strobe one cycle, answer one cycle later
  // ----------------------------------------------------------------
  task automatic xfer(input logic [`CHO_CMD_W-1:0] cmd, input logic wr,
                      input logic [`CHO_DATA_W-1:0] wd, output logic [`CHO_DATA_W-1:0] rd);
    @(posedge sys_clk_i);
    cmd_o <= cmd;
    wr_o <= wr;
    rd_o <= ~wr;
    wdata_o <= wd;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // Released lines flip so stale values cannot pass
    cmd_o <= ~cmd;
    wdata_o <= ~wd;
    @(posedge sys_clk_i);
    #1;
    rd = rdata_i;
  endtask
endmodule // cho_host_model

/* test/tb_top.sv */
/*
  Self-checking bench of the option register and learn sequencer.
  Assumes the host model drives the command port; analog inputs from here.
*/
`timescale 1ns/1ps
`include "cho_defines.svh"

module tb_top;
  import cho_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [`CHO_CMD_W-1:0] cmd;
  logic wr;
  logic rd;
  cho_word_t wdata;
  cho_word_t rdata;
  cho_word_t r;
  logic adp_sense = 1'b0;
  logic depl = 1'b0;
  logic cvz = 1'b0;
  logic hs, ls, mon, ocp, inh, asw, bsw;
  logic [1:0] dsel;
  int n_fail = 0;
  int comparisons = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  cho_host_model cho_host_model_inst (.sys_clk_i(sys_clk_i), .cmd_o(cmd), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));

  cho_option cho_option_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .opt_cmd_i(cmd),
    .opt_wr_i(wr), .opt_rd_i(rd), .opt_wdata_i(wdata), .adapter_sense_input_i(adp_sense),
    .batt_depleted_i(depl), .charge_voltage_zero_i(cvz), .opt_rdata_o(rdata),
    .high_side_short_threshold_sel_o(hs), .low_side_short_threshold_sel_o(ls),
    .current_monitor_output_sel_o(mon), .input_overcurrent_protect_en_o(ocp),
    .charge_inhibit_o(inh), .depletion_threshold_sel_o(dsel),
    .adapter_path_switch_o(asw), .battery_path_switch_o(bsw));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input cho_word_t got, input cho_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Output image: depl, hs, ls, mon, ocp, inhibit, adapter sw, battery sw
  function automatic cho_word_t outs();
    return {7'h00, dsel, hs, ls, mon, ocp, inh, asw, bsw};
  endfunction

  task automatic wr_opt(input cho_word_t v);
    cho_host_model_inst.xfer(`CHO_CMD_OPTION, 1'b1, v, r);
  endtask

  task automatic rd_opt(input logic [`CHO_CMD_W-1:0] c, input cho_word_t exp);
    cho_host_model_inst.xfer(c, 1'b0, 16'h0000, r);
    chk(r, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk(outs(), 16'h01CA);
    rd_opt(`CHO_CMD_OPTION, 16'h1902);
  endtask

  task automatic t_fields();
    wr_opt(16'hFFBF);
    chk(outs(), 16'h01FE);
    rd_opt(`CHO_CMD_OPTION, 16'h19A3);
    wr_opt(16'h0000);
    chk(outs(), 16'h0002);
    rd_opt(`CHO_CMD_OPTION, 16'h0000);
  endtask

  task automatic t_adapter();
    @(posedge sys_clk_i);
    adp_sense <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    wr_opt(16'h1902);
    rd_opt(`CHO_CMD_OPTION, 16'h1912);
  endtask

  task automatic t_learn();
    wr_opt(16'h1942);
    chk(outs(), 16'h01C9);
    @(posedge sys_clk_i);
    depl <= 1'b1;
    // Bounded wait for the synchronised end of learning
    // Look after the edge has settled; read-back lands two cycles after completion
    for (int i = 0; i < 12 && bsw !== 1'b0; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    #1;
    chk(outs(), 16'h01CA);
    rd_opt(`CHO_CMD_OPTION, 16'h1912);
    depl <= 1'b0;
  endtask

  task automatic t_cvzero_abort();
    @(posedge sys_clk_i);
    cvz <= 1'b1;
    wr_opt(16'h1942);
    @(posedge sys_clk_i);
    depl <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    #1;
    chk(outs(), 16'h01C9);
    wr_opt(16'h1902);
    chk(outs(), 16'h01CA);
    rd_opt(`CHO_CMD_OPTION, 16'h1912);
    depl <= 1'b0;
    cvz <= 1'b0;
  endtask

  task automatic t_badcmd();
    cho_host_model_inst.xfer(8'h13, 1'b1, 16'h0000, r);
    rd_opt(8'h13, 16'h0000);
    rd_opt(`CHO_CMD_OPTION, 16'h1912);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_reset();
    t_fields();
    t_adapter();
    t_learn();
    t_cvzero_abort();
    t_badcmd();
    finish_test();
  end

  // Whole run is under a hundred cycles
  initial begin
    #100us;
    n_fail++;
    finish_test();
  end
endmodule // tb_top
